// [ffmr_pkg.sv]
// Package: constants for the fail-safe fault mask and report block
// How it works
// (R1) Fail-safe entry reloads all config first
// (R2) Compute checksum, store, compare with reference
// (R3) Mismatch: outputs off, line low, flags set
// (R4) Programmer writes correct reference checksum
// (R5) Mask per channel and per fault type
// (R6) Mask blocks only aggregate, summary, line
// (R7) Diag enable 0: no channel fault reported
// (R8) Low supply: flag, summary if unmasked, no line
// (R9) Supply UV: outputs off, flag, masked reporting
// (R10) Reference fault: outputs off, flag, masked report
// (R11) Prethermal: flag, summary if unmasked, no line
// (R12) Overtemp: flag, masked summary and line
// (R13) Checksum error: flag, masked summary and line
// (R14) Open fault: flag, masked aggregate and line
// (R15) Short fault: flag, masked aggregate and line
// (R16) Single short: flag, masked aggregate and line
// (R17) Rail UV: reset flag, summary, line low
// (R18) Clear-faults command clears latched flags, self-clears
// (R19) Clear-reset command clears reset flag, self-clears
// (R20) Inputs are levels; flags sticky on rising
package ffmr_pkg;
	localparam int NCH = 24; // Output channels
	localparam int AW = 8; // Register address width
	localparam int NVW = 16; // Config image entries
	localparam int CKW = 16; // Checksum width
	// Register word offsets
	localparam logic [7:0] A_CTRL = 8'h00; // Commands
	localparam logic [7:0] A_MASK = 8'h04; // Type masks
	localparam logic [7:0] A_STAT = 8'h08; // Global flags
	localparam logic [7:0] A_OPEN = 8'h0C; // Open flags
	localparam logic [7:0] A_SHRT = 8'h10; // Short flags
	localparam logic [7:0] A_SLS = 8'h14; // Single-short flags
	localparam logic [7:0] A_CKS = 8'h18; // Checksums
	localparam logic [7:0] A_CMSK = 8'h1C; // Channel masks
	localparam logic [7:0] A_DIAG = 8'h20; // Loaded diag enables
	// Control bits
	localparam int B_CLRF = 0; // Clear faults command
	localparam int B_CLRP = 1; // Clear power-up command
	// Mask and flag bit positions
	localparam int M_LOWSUP = 0;
	localparam int M_SUPUV = 1;
	localparam int M_REF = 2;
	localparam int M_PRET = 3;
	localparam int M_OT = 4;
	localparam int M_CKS = 5;
	localparam int M_OPEN = 6;
	localparam int M_SHORT = 7;
	localparam int M_SLS = 8;
	localparam int NMASK = 9;
	localparam int F_POR = 9; // Reset flag bit in status
	localparam int F_OUT = 10; // Aggregated output flag
	localparam int F_ERR = 11; // Summary flag
	localparam int F_CKBUSY = 12; // Checksum check running
	localparam logic [NMASK-1:0] MASK_RST = 9'h000; // All unmasked
	localparam logic [CKW-1:0] CK_SEED = 16'hFFFF; // Checksum seed
	localparam logic [CKW-1:0] CK_POLY = 16'h1021; // Checksum polynomial
endpackage : ffmr_pkg

// [ffmr_cksum.sv]
// Running checksum over config words, one word per cycle
module ffmr_cksum (
	input wire logic i_clk, // Clock
	input wire logic i_rst_b, // Async reset, low
	input wire logic i_start, // Reseed accumulator
	input wire logic i_valid, // Word present
	input wire logic [ffmr_pkg::CKW-1:0] i_word, // Word
	output logic [ffmr_pkg::CKW-1:0] o_sum // Accumulated checksum
);
	logic [ffmr_pkg::CKW-1:0] sum_r;
	logic [ffmr_pkg::CKW-1:0] sum_nxt;

	// Bitwise shift register fold; whole word per cycle
	always_comb begin
		sum_nxt = sum_r ^ i_word;
		for (int b = 0; b < ffmr_pkg::CKW; b++) begin
			if (sum_nxt[ffmr_pkg::CKW-1]) begin
				sum_nxt = {sum_nxt[ffmr_pkg::CKW-2:0], 1'b0} ^ ffmr_pkg::CK_POLY;
			end else begin
				sum_nxt = {sum_nxt[ffmr_pkg::CKW-2:0], 1'b0};
			end
		end
	end

	// Accumulator
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sum_r <= ffmr_pkg::CK_SEED;
		end else if (i_start) begin
			sum_r <= ffmr_pkg::CK_SEED;
		end else if (i_valid) begin
			sum_r <= sum_nxt;
		end
	end

	assign o_sum = sum_r;
endmodule : ffmr_cksum

// [ffmr_top.sv]
// Fail-safe fault latching, masking and fault line drive
module ffmr_top (
	input wire logic i_clk, // 100 MHz clock
	input wire logic i_rst_b, // Async reset, low
	input wire logic i_failsafe_enter, // Pulse: fail-safe entered
	output logic [3:0] o_nv_addr, // Config image address
	input wire logic [ffmr_pkg::CKW-1:0] i_nv_data, // Image word, next cycle
	input wire logic [ffmr_pkg::CKW-1:0] i_stored_config_checksum, // Reference
	output logic [ffmr_pkg::NCH-1:0] o_channel_diag_enable, // Loaded enables
	output logic o_cfg_load, // High while reloading config
	input wire logic i_low_supply, // Level faults from comparators
	input wire logic i_supply_uv,
	input wire logic i_reference_fault,
	input wire logic i_prethermal,
	input wire logic i_overtemp,
	input wire logic i_rail_uv, // Battery or regulator UV
	input wire logic [ffmr_pkg::NCH-1:0] i_open, // Per-channel open
	input wire logic [ffmr_pkg::NCH-1:0] i_short, // Per-channel short
	input wire logic [ffmr_pkg::NCH-1:0] i_single_short, // Per-channel single short
	output logic o_all_off, // Turn off all outputs
	output logic o_force_por, // Hold device in reset state
	output logic o_fault_out, // Fault line drive value (always 0)
	output logic o_fault_oe, // Fault line pulled low when high
	input wire logic [ffmr_pkg::AW-1:0] i_addr, // Register address
	input wire logic [31:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [31:0] o_rdata // Read data, cycle after strobe
);
	localparam int NCH = ffmr_pkg::NCH;

	typedef enum logic [1:0] {FFMR_IDLE, FFMR_LOAD, FFMR_CHECK} ffmr_st_t;
	ffmr_st_t st_r; // Reload sequencer

	logic [3:0] idx_r; // Word being fetched
	logic fetch_v_r; // Word on i_nv_data valid
	logic [3:0] widx_r; // Index of that word
	logic [NCH-1:0] diag_r; // Channel diag enables from image
	logic [NCH-1:0] chmask_r; // Per-channel report masks
	logic [ffmr_pkg::NMASK-1:0] mask_r; // Per-type masks
	logic [ffmr_pkg::CKW-1:0] calc_r; // Computed config checksum
	logic [ffmr_pkg::CKW-1:0] sum; // Accumulator output
	logic ck_busy_r; // Check in progress
	// Sticky flags
	logic low_supply_flag_r, supply_uv_flag_r, ref_flag_r;
	logic prethermal_flag_r, overtemp_flag_r, config_checksum_flag_r;
	logic por_flag_r, out_flag_r, err_flag_r;
	logic [NCH-1:0] channel_open_flag_r, channel_short_flag_r, channel_single_short_flag_r;
	logic [5:0] prev_r; // Previous global input levels
	logic [NCH-1:0] prev_open_r, prev_short_r, prev_sls_r;
	logic [31:0] rdata_r;

	// Channel events gated by diag enable, rising level only
	wire [NCH-1:0] ev_open = i_open & ~prev_open_r & diag_r; // R7 R20
	wire [NCH-1:0] ev_short = i_short & ~prev_short_r & diag_r; // R7 R20
	wire [NCH-1:0] ev_sls = i_single_short & ~prev_sls_r & diag_r; // R7 R20
	wire [5:0] lv = {i_rail_uv, i_overtemp, i_prethermal, i_reference_fault, i_supply_uv, i_low_supply};
	wire [5:0] ev = lv & ~prev_r; // R20
	wire ck_mismatch; // Checksum compare result pulse
	wire ck_done = (st_r == FFMR_CHECK);
	assign ck_mismatch = ck_done && (calc_r != i_stored_config_checksum); // R2 R4

	// Per-channel reporting: type mask and channel mask both block it
	wire [NCH-1:0] rep_ch = ~chmask_r & ( // R5
		(ev_open & {NCH{~mask_r[ffmr_pkg::M_OPEN]}}) | // R14
		(ev_short & {NCH{~mask_r[ffmr_pkg::M_SHORT]}}) | // R15
		(ev_sls & {NCH{~mask_r[ffmr_pkg::M_SLS]}})); // R16
	wire rep_out = |rep_ch; // R6
	wire rep_glob = (ev[0] & ~mask_r[ffmr_pkg::M_LOWSUP]) | // R8
		(ev[1] & ~mask_r[ffmr_pkg::M_SUPUV]) | // R9
		(ev[2] & ~mask_r[ffmr_pkg::M_REF]) | // R10
		(ev[3] & ~mask_r[ffmr_pkg::M_PRET]) | // R11
		(ev[4] & ~mask_r[ffmr_pkg::M_OT]) | // R12
		(ck_mismatch & ~mask_r[ffmr_pkg::M_CKS]) | ev[5]; // R13 R17

	// Commands self-clear: they are pulses, never stored
	wire wr_ctrl = i_wr && (i_addr == ffmr_pkg::A_CTRL);
	wire clr_f = wr_ctrl && i_wdata[ffmr_pkg::B_CLRF]; // R18
	wire clr_p = wr_ctrl && i_wdata[ffmr_pkg::B_CLRP]; // R19

	// Reload sequencer: fetch every word, then compare
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= FFMR_IDLE;
			idx_r <= 4'h0;
		end else begin
			case (st_r)
				FFMR_IDLE: begin
					if (i_failsafe_enter) begin
						st_r <= FFMR_LOAD; // R1
						idx_r <= 4'h0;
					end
				end
				FFMR_LOAD: begin
					if (idx_r == 4'hF) begin
						st_r <= FFMR_IDLE; // Final word still in flight
					end
					idx_r <= idx_r + 4'h1;
				end
				default: st_r <= FFMR_IDLE;
			endcase
			if (fetch_v_r && widx_r == 4'hF) begin
				st_r <= FFMR_CHECK; // R2: compare after last word
			end
		end
	end

	// Fetch pipeline and config load
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fetch_v_r <= 1'b0;
			widx_r <= 4'h0;
			diag_r <= {NCH{1'b1}};
			calc_r <= 16'h0000;
			ck_busy_r <= 1'b0;
		end else begin
			fetch_v_r <= (st_r == FFMR_LOAD);
			widx_r <= idx_r;
			if (st_r == FFMR_LOAD) begin
				ck_busy_r <= 1'b1;
			end else if (ck_done) begin
				ck_busy_r <= 1'b0;
			end
			// Words 0 and 1 hold the diag enables
			if (fetch_v_r && widx_r == 4'h0) begin
				diag_r[15:0] <= i_nv_data; // R1
			end
			if (fetch_v_r && widx_r == 4'h1) begin
				diag_r[NCH-1:16] <= i_nv_data[NCH-17:0]; // R1
			end
			if (fetch_v_r && widx_r == 4'hF) begin
				calc_r <= sum; // R2
			end
		end
	end

	// Checksum covers image words 0 to 14, each only after it lands
	ffmr_cksum u_ck (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_start(st_r == FFMR_IDLE && i_failsafe_enter),
		.i_valid(fetch_v_r && widx_r != 4'hF),
		.i_word(i_nv_data),
		.o_sum(sum)
	);

	// Sticky flags; a set in the clear cycle wins
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_r <= 6'h00;
			prev_open_r <= '0;
			prev_short_r <= '0;
			prev_sls_r <= '0;
			{low_supply_flag_r, supply_uv_flag_r, ref_flag_r} <= 3'h0;
			{prethermal_flag_r, overtemp_flag_r, config_checksum_flag_r} <= 3'h0;
			por_flag_r <= 1'b1; // Power-up itself is a reset event
			out_flag_r <= 1'b0;
			err_flag_r <= 1'b1;
			channel_open_flag_r <= '0;
			channel_short_flag_r <= '0;
			channel_single_short_flag_r <= '0;
		end else begin
			prev_r <= lv;
			prev_open_r <= i_open;
			prev_short_r <= i_short;
			prev_sls_r <= i_single_short;
			low_supply_flag_r <= ev[0] | (low_supply_flag_r & ~clr_f); // R8 R18
			supply_uv_flag_r <= ev[1] | (supply_uv_flag_r & ~clr_f); // R9
			ref_flag_r <= ev[2] | (ref_flag_r & ~clr_f); // R10
			prethermal_flag_r <= ev[3] | (prethermal_flag_r & ~clr_f); // R11
			overtemp_flag_r <= ev[4] | (overtemp_flag_r & ~clr_f); // R12
			config_checksum_flag_r <= ck_mismatch | (config_checksum_flag_r & ~clr_f); // R3 R13
			por_flag_r <= ev[5] | (por_flag_r & ~clr_p); // R17 R19
			channel_open_flag_r <= ev_open | (channel_open_flag_r & {NCH{~clr_f}}); // R6 R14
			channel_short_flag_r <= ev_short | (channel_short_flag_r & {NCH{~clr_f}}); // R15
			channel_single_short_flag_r <= ev_sls | (channel_single_short_flag_r & {NCH{~clr_f}}); // R16
			out_flag_r <= rep_out | (out_flag_r & ~clr_f); // R6
			// Summary flag cleared by either command
			err_flag_r <= rep_glob | rep_out | (err_flag_r & ~clr_f & ~clr_p); // R3 R18 R19
		end
	end

	// Fault line: critical unmasked conditions hold it low while present
	wire line_glob = (i_supply_uv & ~mask_r[ffmr_pkg::M_SUPUV]) | // R9
		(i_reference_fault & ~mask_r[ffmr_pkg::M_REF]) | // R10
		(i_overtemp & ~mask_r[ffmr_pkg::M_OT]) | // R12
		(config_checksum_flag_r & ~mask_r[ffmr_pkg::M_CKS]) | i_rail_uv; // R3 R13 R17
	wire [NCH-1:0] line_ch = diag_r & ~chmask_r & ( // R7
		(i_open & {NCH{~mask_r[ffmr_pkg::M_OPEN]}}) | // R14
		(i_short & {NCH{~mask_r[ffmr_pkg::M_SHORT]}}) | // R15
		(i_single_short & {NCH{~mask_r[ffmr_pkg::M_SLS]}})); // R16
	assign o_fault_oe = line_glob | (|line_ch); // R8 R11: warnings never pull
	assign o_fault_out = 1'b0;
	assign o_all_off = i_supply_uv | i_reference_fault | config_checksum_flag_r; // R3 R9 R10
	assign o_force_por = i_rail_uv; // R17
	assign o_nv_addr = idx_r;
	assign o_cfg_load = ck_busy_r;
	assign o_channel_diag_enable = diag_r;

	// Mask registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mask_r <= ffmr_pkg::MASK_RST;
			chmask_r <= '0;
		end else if (i_wr && i_addr == ffmr_pkg::A_MASK) begin
			mask_r <= i_wdata[ffmr_pkg::NMASK-1:0]; // R5
		end else if (i_wr && i_addr == ffmr_pkg::A_CMSK) begin
			chmask_r <= i_wdata[NCH-1:0]; // R5
		end
	end

	// Read mux; commands read back as zero
	wire [12:0] stat_w = {ck_busy_r, err_flag_r, out_flag_r, por_flag_r, 3'h0,
		config_checksum_flag_r, overtemp_flag_r, prethermal_flag_r, ref_flag_r,
		supply_uv_flag_r, low_supply_flag_r};
	logic [31:0] rmux;
	always_comb begin
		case (i_addr)
			ffmr_pkg::A_MASK: rmux = {23'h0, mask_r};
			ffmr_pkg::A_STAT: rmux = {19'h0, stat_w};
			ffmr_pkg::A_OPEN: rmux = {8'h00, channel_open_flag_r};
			ffmr_pkg::A_SHRT: rmux = {8'h00, channel_short_flag_r};
			ffmr_pkg::A_SLS: rmux = {8'h00, channel_single_short_flag_r};
			ffmr_pkg::A_CKS: rmux = {i_stored_config_checksum, calc_r};
			ffmr_pkg::A_CMSK: rmux = {8'h00, chmask_r};
			ffmr_pkg::A_DIAG: rmux = {8'h00, diag_r};
			default: rmux = 32'h0000_0000; // Control and unmapped
		endcase
	end

	// Read data register, valid only the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= i_rd ? rmux : 32'h0000_0000;
		end
	end
	assign o_rdata = rdata_r;
endmodule : ffmr_top

// [ffmr_properties.sv]
// Port checks for the fail-safe fault mask and report block
module ffmr_properties (
	input wire logic i_clk, // Clock
	input wire logic i_rst_b, // Reset, low
	input wire logic i_failsafe_enter, // Reload pulse
	input wire logic [3:0] o_nv_addr, // Image address
	input wire logic o_cfg_load, // Reload running
	input wire logic i_supply_uv, // Supply UV
	input wire logic i_reference_fault, // Reference fault
	input wire logic i_rail_uv, // Rail UV
	input wire logic o_all_off, // Outputs off
	input wire logic o_force_por, // Reset hold
	input wire logic o_fault_out, // Line value
	input wire logic o_fault_oe, // Line pulled
	input wire logic [ffmr_pkg::AW-1:0] i_addr, // Address
	input wire logic i_rd, // Read strobe
	input wire logic [31:0] o_rdata // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// First image words leave in address order
	sequence s_walk;
		(o_nv_addr == 4'h0) ##1 (o_nv_addr == 4'h1) ##1 (o_nv_addr == 4'h2);
	endsequence
	// Busy spans the last 15 fetches, the last word in flight and the compare, then ends
	sequence s_span;
		o_cfg_load [*8] ##1 o_cfg_load [*8] ##1 o_cfg_load ##1 !o_cfg_load;
	endsequence
	// Busy is registered off the load state, so it trails the pulse by two edges
	load_start_a: assert property (i_failsafe_enter && !o_cfg_load |=> ##1 o_cfg_load)
		else $error("reload did not start");
	// Address 0 stands in the cycle right after the pulse is taken
	addr_walk_a: assert property (i_failsafe_enter && !o_cfg_load |=> s_walk)
		else $error("image address order wrong");
	load_span_a: assert property ($rose(o_cfg_load) |-> s_span)
		else $error("reload length wrong");
	ctrl_zero_a: assert property (i_rd && i_addr == ffmr_pkg::A_CTRL |=> o_rdata == 32'h0)
		else $error("command bits read back set");
	por_follow_a: assert property (o_force_por == i_rail_uv)
		else $error("reset hold does not follow rail");
	por_line_a: assert property (i_rail_uv |-> o_fault_oe)
		else $error("rail fault left line free");
	line_low_a: assert property (o_fault_oe |-> o_fault_out == 1'b0)
		else $error("fault line driven high");
	uv_off_a: assert property ($rose(i_supply_uv) |=> o_all_off)
		else $error("supply fault left outputs on");
	ref_off_a: assert property ($rose(i_reference_fault) |=> o_all_off)
		else $error("reference fault left outputs on");
endmodule : ffmr_properties

bind ffmr_top ffmr_properties u_props (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_failsafe_enter(i_failsafe_enter),
	.o_nv_addr(o_nv_addr), .o_cfg_load(o_cfg_load), .i_supply_uv(i_supply_uv),
	.i_reference_fault(i_reference_fault), .i_rail_uv(i_rail_uv), .o_all_off(o_all_off),
	.o_force_por(o_force_por), .o_fault_out(o_fault_out), .o_fault_oe(o_fault_oe), .i_addr(i_addr),
	.i_rd(i_rd), .o_rdata(o_rdata));

// [ffmr_nv_model.sv]
// Config image memory answering one cycle behind its address
module ffmr_nv_model (
	input wire logic i_clk, // Clock
	input wire logic [3:0] i_addr, // Word address
	output logic [ffmr_pkg::CKW-1:0] o_data // Word, next cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ffmr_pkg::CKW-1:0] mem [16]; // Image, filled by bench
	// Registered read, so the block must wait a cycle
	always_ff @(posedge i_clk) begin
		o_data <= mem[i_addr];
	end
endmodule : ffmr_nv_model

// [tb_failsafe_fault_mask_report.sv]
// Self-checking bench for the fail-safe fault mask and report block
module tb_failsafe_fault_mask_report;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 0, i_rst_b = 0, fs = 0, rail = 0, i_wr = 0, i_rd = 0, rd_d = 0;
	logic [4:0] flt = '0; // Global faults, mask bit order
	logic [4:0] line = 5'h16; // Types that pull the line
	logic [23:0] chf [3] = '{default: '0}; // Open, short, single
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0, rdata, rs = 32'hC83ED86D;
	logic [15:0] nvd, ref_ck = '0;
	logic [23:0] diag;
	logic [3:0] nva;
	logic load, all_off, por, fout, oe;
	logic [31:0] expq [$]; // Expected read data
	int errors = 0, n_tests = 0, cyc = 0, ch;
	ffmr_nv_model u_nv (.i_clk(i_clk), .i_addr(nva), .o_data(nvd));
	ffmr_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_failsafe_enter(fs), .o_nv_addr(nva),
		.i_nv_data(nvd), .i_stored_config_checksum(ref_ck), .o_channel_diag_enable(diag),
		.o_cfg_load(load), .i_low_supply(flt[0]), .i_supply_uv(flt[1]), .i_reference_fault(flt[2]),
		.i_prethermal(flt[3]), .i_overtemp(flt[4]), .i_rail_uv(rail), .i_open(chf[0]),
		.i_short(chf[1]), .i_single_short(chf[2]), .o_all_off(all_off), .o_force_por(por),
		.o_fault_out(fout), .o_fault_oe(oe), .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(rdata));
	initial forever #5 i_clk = ~i_clk;
	// Xorshift source for channels and image words
	function automatic logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : nxt
	// Reference checksum over words 0 to 14
	function automatic logic [15:0] crc();
		logic [15:0] c = ffmr_pkg::CK_SEED;
		for (int w = 0; w < 15; w++) begin
			c ^= u_nv.mem[w];
			for (int b = 0; b < 16; b++) c = c[15] ? (c << 1) ^ ffmr_pkg::CK_POLY : c << 1;
		end
		return c;
	endfunction : crc
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic summarize();
		if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	// Read noted in the queue; the watcher compares it
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		addr <= a;
		expq.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask : rd
	// Reload with a right or a spoiled reference, checksum mask as given
	task automatic reload(input logic bad, input logic msk);
		wr(ffmr_pkg::A_MASK, 32'(msk) << ffmr_pkg::M_CKS);
		ref_ck <= crc() ^ {16{bad}};
		@(posedge i_clk);
		fs <= 1'b1;
		@(posedge i_clk);
		fs <= 1'b0;
		repeat (3) @(posedge i_clk);
		for (int i = 0; i < 40 && load; i++) @(posedge i_clk);
		settle(2);
		check(32'(oe), 32'(bad && !msk));
		check(32'(fout), 32'h0);
		check(32'(all_off), 32'(bad));
		rd(ffmr_pkg::A_CKS, {ref_ck, crc()});
		rd(ffmr_pkg::A_STAT, bad ? (msk ? 32'h20 : 32'h820) : 32'h0);
	endtask : reload
	// Watcher: read data stands the cycle after the strobe
	always @(posedge i_clk) begin
		rd_d <= i_rd;
		if (rd_d) check(rdata, expq.pop_front());
		cyc++;
		if (cyc == 5000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		u_nv.mem[0] = 16'hFFFE; // Channel 0 diagnostics off
		u_nv.mem[1] = 16'h00FF;
		for (int w = 2; w < 16; w++) u_nv.mem[w] = 16'(nxt());
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(ffmr_pkg::A_STAT, 32'hA00);
		rd(ffmr_pkg::A_MASK, 32'h0);
		rd(8'h3C, 32'h0);
		rd(ffmr_pkg::A_CTRL, 32'h0);
		rail <= 1'b1;
		settle(2);
		check(32'(oe), 32'h1);
		check(32'(por), 32'h1);
		rail <= 1'b0;
		wr(ffmr_pkg::A_CTRL, 32'h1);
		rd(ffmr_pkg::A_STAT, 32'h200);
		wr(ffmr_pkg::A_CTRL, 32'h2);
		rd(ffmr_pkg::A_STAT, 32'h0);
		// Global fault types at mask bits 0 to 4, unmasked then masked
		for (int k = 0; k < 5; k++) begin
			for (int m = 0; m < 2; m++) begin
				wr(ffmr_pkg::A_MASK, 32'(m) << k);
				flt[k] <= 1'b1;
				settle(2);
				check(32'(oe), 32'(line[k] && m == 0));
				check(32'(all_off), 32'(k == 1 || k == 2));
				rd(ffmr_pkg::A_STAT, (32'h1 << k) | (m ? 32'h0 : 32'h800));
				flt[k] <= 1'b0;
				wr(ffmr_pkg::A_CTRL, 32'h1);
				rd(ffmr_pkg::A_STAT, 32'h0);
			end
		end
		wr(ffmr_pkg::A_MASK, 32'h0);
		reload(1'b0, 1'b0);
		check(32'(diag), 32'h00FFFFFE);
		rd(ffmr_pkg::A_DIAG, 32'h00FFFFFE);
		chf[0][0] <= 1'b1;
		settle(2);
		check(32'(oe), 32'h0);
		rd(ffmr_pkg::A_OPEN, 32'h0);
		rd(ffmr_pkg::A_STAT, 32'h0);
		chf[0][0] <= 1'b0;
		reload(1'b1, 1'b0);
		wr(ffmr_pkg::A_CTRL, 32'h1);
		rd(ffmr_pkg::A_STAT, 32'h0);
		// Masked checksum error: flag and outputs off, no summary, line stays free
		reload(1'b1, 1'b1);
		wr(ffmr_pkg::A_CTRL, 32'h1);
		rd(ffmr_pkg::A_STAT, 32'h0);
		// Channel faults: free, type masked, channel masked
		for (int t = 0; t < 3; t++) begin
			for (int m = 0; m < 3; m++) begin
				ch = 1 + int'(nxt() % 23);
				wr(ffmr_pkg::A_MASK, 32'(m == 1) << (6 + t));
				wr(ffmr_pkg::A_CMSK, 32'(m == 2) << ch);
				chf[t][ch] <= 1'b1;
				settle(2);
				check(32'(oe), 32'(m == 0));
				rd(ffmr_pkg::A_OPEN + 8'(4 * t), 32'h1 << ch);
				rd(ffmr_pkg::A_STAT, m ? 32'h0 : 32'hC00);
				chf[t][ch] <= 1'b0;
				wr(ffmr_pkg::A_CTRL, 32'h1);
				rd(ffmr_pkg::A_OPEN + 8'(4 * t), 32'h0);
			end
		end
		settle(3);
		summarize();
	end
endmodule : tb_failsafe_fault_mask_report
